// file: cfg_pkt_pkg.sv
// constants and carrier types shared by the configuration packet processor
package cfg_pkt_pkg;

  // stream words
  localparam logic [31:0] SYNC_WORD        = 32'hAA99_5566;
  localparam logic [31:0] IDLE_WORD        = 32'h2000_0000;

  // header field positions
  localparam int          HDR_TYPE_MSB     = 31;
  localparam int          HDR_TYPE_LSB     = 29;
  localparam int          HDR_OP_MSB       = 28;
  localparam int          HDR_OP_LSB       = 27;
  localparam int          HDR_ADDR_MSB     = 17;
  localparam int          HDR_ADDR_LSB     = 13;
  localparam int          HDR_COUNT_MSB    = 10;
  localparam int          HDR_COUNT_LSB    = 0;
  localparam logic [2:0]  PKT_TYPE_1       = 3'h1;
  localparam logic [1:0]  OP_WRITE         = 2'h2;

  // register addresses carried in bits 17:13 of a header
  localparam logic [4:0]  ADDR_FRAME       = 5'h01;
  localparam logic [4:0]  ADDR_COMMAND     = 5'h04;
  localparam logic [4:0]  ADDR_CONTROL_WORD_0        = 5'h05;
  localparam logic [4:0]  ADDR_GATE        = 5'h06;
  localparam logic [4:0]  ADDR_OPT0        = 5'h09;
  localparam logic [4:0]  ADDR_IDENT       = 5'h0C;
  localparam logic [4:0]  ADDR_OPT1        = 5'h0E;
  localparam logic [4:0]  ADDR_WARM_BOOT   = 5'h10;
  localparam logic [4:0]  ADDR_WATCHDOG    = 5'h11;
  localparam logic [4:0]  ADDR_RESERVED    = 5'h13;
  localparam logic [4:0]  ADDR_CONTROL_WORD_1        = 5'h18;

  // command codes in bits 4:0 of the command register
  localparam int          CMD_MSB          = 4;
  localparam logic [4:0]  CMD_NULL         = 5'h00;
  localparam logic [4:0]  CMD_CRC_CLEAR    = 5'h07;
  localparam logic [4:0]  CMD_CLOCK_SWITCH = 5'h09;
  localparam logic [4:0]  CMD_ALIGN_RELEASE = 5'h0D;

  // clock frequency select field of option word 0
  localparam int          FREQ_LSB         = 17;
  localparam int          FREQ_WIDTH       = 6;

  // reset values and crc polynomial
  localparam logic [31:0] REG_RESET        = 32'h0000_0000;
  localparam logic [31:0] CRC_RESET        = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY         = 32'h04C1_1DB7;
  // arbitrary value, stands in for the part's own identity code
  localparam logic [31:0] DEVICE_ID_DEFAULT = 32'h0A5A_1234;

  // settle time after a clock switch
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          SWITCH_SETTLE_NS = 200;
  localparam int          SWITCH_SETTLE_CYCLES =
    (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [2:0]  pkt_type;
    logic [1:0]  opcode;
    logic [4:0]  addr;
    logic [10:0] count;
  } header_type;

  typedef struct packed {
    logic [31:0] fallback_watchdog_value;
    logic [31:0] warm_boot_start_address;
    logic [31:0] command_reg;
    logic [31:0] frame_address;
    logic [31:0] config_option_0;
    logic [31:0] config_option_1;
    logic [31:0] device_identity_check;
    logic [31:0] control_write_gate;
    logic [31:0] control_word_0;
    logic [31:0] control_word_1;
  } cfg_regs_type;

endpackage

// file: cfg_word_source.sv
// behavioural configuration word source
module cfg_word_source (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // word stream
  output logic             word_valid,
  output logic [31:0]      word_data,
  input  wire logic        word_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  bit hung = 1'b0;
  int refused = 0;

  initial begin
    word_valid = 1'b0;
    word_data = 32'h0000_0000;
  end
  // ready is registered, so its settled value is what the next edge samples
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    word_valid = 1'b1;
    word_data = w;
    while (word_ready !== 1'b1 && n < 200) begin
      refused++;
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 200) hung = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  // the data line is not pulled, so a released line shows the inverse word
  task automatic idle(input int cycles);
    word_valid = 1'b0;
    word_data = ~word_data;
    repeat (cycles) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic preamble();
    repeat (16) send(32'hFFFF_FFFF);
    send(32'h0000_00BB);
    send(32'h1122_0044);
    repeat (2) send(32'hFFFF_FFFF);
  endtask
endmodule

// file: config_packet_processor.sv
// configuration packet processor with its input word fifo
////////////////////////////////////////////////////////////////////////////////
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign out_valid  = (count_reg != '0);
  assign out_data   = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      // registered so the top-level ready comes straight from a flop
      in_ready  <= (count_next != (AW + 1)'(DEPTH));
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Function
// - after alignment every 32-bit word is a packet or part of one
// - ignore everything until AA995566 arrives; then word boundary is locked
// - 20000000 is an idle word with no effect
// - 30008001 writes command; 30022001 writes fallback watchdog value
// - 30020001 writes warm-boot address; 30002001 writes frame address
// - 30012001 writes option word 0; 3001C001 writes option word 1
// - 30018001 writes identity check; 3000C001 writes control write gate
// - 3000A001 writes control word 0; 30030001 writes control word 1
// - 30026001 and its payload are accepted with no effect
// - fallback watchdog value holds a 32-bit count
// - warm-boot address holds the 32-bit next image address
// - command code sits in bits 4:0; code 00000 changes nothing
// - code 00111 clears running crc; later words fall in coverage
// - code 01001 switches config clock to option word 0 frequency
// - identity value differing from own code flags a configuration error
// - control word writes change only bits enabled by the gate register
// - option word 0 holds clock source, frequency and start-up settings
// - option word 1 holds flash page mode and similar options
// - control word 0 holds fallback and readback control options
// - control word 1 is reserved; writes of zero have no effect; here writes pass the gate, so zero clears gated bits
// - code 01101 clears alignment; wait for a fresh alignment word
module config_packet_processor #(
  parameter logic [31:0] DEVICE_ID  = cfg_pkt_pkg::DEVICE_ID_DEFAULT,
  parameter int          FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      reprogram_req,
  // incoming configuration words
  input  wire logic                      word_valid,
  input  wire logic [31:0]               word_data,
  output logic                           word_ready,
  // register contents
  output cfg_pkt_pkg::cfg_regs_type      cfg_regs,
  // status and events
  output logic                           word_aligned_flag,
  output logic                           config_error,
  output logic                           crc_covering,
  output logic [31:0]                    crc_value,
  output logic                           crc_clear_pulse,
  output logic                           clock_switch_pulse,
  output logic [cfg_pkt_pkg::FREQ_WIDTH-1:0] config_clock_select
);

  typedef enum logic [2:0] {
    ST_HUNT    = 3'b001,
    ST_HEADER  = 3'b010,
    ST_PAYLOAD = 3'b100
  } state_type;

  localparam int SETTLE_W = $clog2(cfg_pkt_pkg::SWITCH_SETTLE_CYCLES + 1);

  state_type                 state_reg;
  logic [4:0]                addr_reg;
  logic [10:0]               remain_reg;
  logic                      write_ok_reg;
  logic [SETTLE_W-1:0]       settle_reg;
  logic                      fifo_valid;
  logic [31:0]               fifo_data;
  logic                      fifo_ready;
  logic                      take;
  logic                      pay_take;
  cfg_pkt_pkg::header_type   hdr;
  logic [4:0]                cmd_code;

  //////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic cfg_pkt_pkg::header_type split_header(input logic [31:0] w);
    cfg_pkt_pkg::header_type h;
    h.pkt_type = w[cfg_pkt_pkg::HDR_TYPE_MSB:cfg_pkt_pkg::HDR_TYPE_LSB];
    h.opcode   = w[cfg_pkt_pkg::HDR_OP_MSB:cfg_pkt_pkg::HDR_OP_LSB];
    h.addr     = w[cfg_pkt_pkg::HDR_ADDR_MSB:cfg_pkt_pkg::HDR_ADDR_LSB];
    h.count    = w[cfg_pkt_pkg::HDR_COUNT_MSB:cfg_pkt_pkg::HDR_COUNT_LSB];
    return h;
  endfunction

  function automatic logic [31:0] gated(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [31:0] gate);
    return (old_val & ~gate) | (new_val & gate);
  endfunction

  function automatic logic [31:0] crc_step(input logic [31:0] crc,
                                           input logic [31:0] w);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ w[i]) ? ((c << 1) ^ cfg_pkt_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // input buffer; a clock switch stalls draining so back-pressure reaches the source

  word_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (word_valid),
    .in_data   (word_data),
    .in_ready  (word_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_ready)
  );

  assign fifo_ready = (settle_reg == '0);
  assign take       = fifo_valid && fifo_ready;
  assign hdr        = split_header(fifo_data);
  assign pay_take   = take && (state_reg == ST_PAYLOAD) && write_ok_reg;
  assign cmd_code   = fifo_data[cfg_pkt_pkg::CMD_MSB:0];

  //////////////////////////////////////////////////////////////////////////////
  // packet state machine

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_HUNT;
      addr_reg     <= '0;
      remain_reg   <= '0;
      write_ok_reg <= 1'b0;
    end else if (reprogram_req) begin
      state_reg    <= ST_HUNT;
      remain_reg   <= '0;
      write_ok_reg <= 1'b0;
    end else if (take) begin
      unique case (state_reg)
        ST_HUNT: begin
          // pad, width-detect and idle words all fall through here unseen
          if (fifo_data == cfg_pkt_pkg::SYNC_WORD) begin
            state_reg <= ST_HEADER;
          end
        end
        ST_HEADER: begin
          // type 1 with a non-zero count opens a payload; idle words leave us here
          if (hdr.pkt_type == cfg_pkt_pkg::PKT_TYPE_1 && hdr.count != '0) begin
            state_reg    <= ST_PAYLOAD;
            addr_reg     <= hdr.addr;
            remain_reg   <= hdr.count;
            write_ok_reg <= (hdr.opcode == cfg_pkt_pkg::OP_WRITE);
          end
        end
        ST_PAYLOAD: begin
          if (write_ok_reg && addr_reg == cfg_pkt_pkg::ADDR_COMMAND &&
              cmd_code == cfg_pkt_pkg::CMD_ALIGN_RELEASE) begin
            state_reg  <= ST_HUNT;
            remain_reg <= '0;
          end else if (remain_reg == 11'd1) begin
            state_reg  <= ST_HEADER;
            remain_reg <= '0;
          end else begin
            remain_reg <= remain_reg - 11'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_aligned_flag <= 1'b0;
    end else begin
      word_aligned_flag <= !reprogram_req &&
        ((state_reg != ST_HUNT) || (take && fifo_data == cfg_pkt_pkg::SYNC_WORD)) &&
        !(pay_take && addr_reg == cfg_pkt_pkg::ADDR_COMMAND &&
          cmd_code == cfg_pkt_pkg::CMD_ALIGN_RELEASE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_regs <= {10{cfg_pkt_pkg::REG_RESET}};
    end else if (reprogram_req) begin
      cfg_regs <= {10{cfg_pkt_pkg::REG_RESET}};
    end else if (pay_take) begin
      unique case (addr_reg)
        cfg_pkt_pkg::ADDR_WATCHDOG:  cfg_regs.fallback_watchdog_value <= fifo_data;
        cfg_pkt_pkg::ADDR_WARM_BOOT: cfg_regs.warm_boot_start_address <= fifo_data;
        cfg_pkt_pkg::ADDR_COMMAND:   cfg_regs.command_reg             <= fifo_data;
        cfg_pkt_pkg::ADDR_FRAME:     cfg_regs.frame_address           <= fifo_data;
        cfg_pkt_pkg::ADDR_OPT0:      cfg_regs.config_option_0         <= fifo_data;
        cfg_pkt_pkg::ADDR_OPT1:      cfg_regs.config_option_1         <= fifo_data;
        cfg_pkt_pkg::ADDR_IDENT:     cfg_regs.device_identity_check   <= fifo_data;
        cfg_pkt_pkg::ADDR_GATE:      cfg_regs.control_write_gate      <= fifo_data;
        cfg_pkt_pkg::ADDR_CONTROL_WORD_0: begin
          cfg_regs.control_word_0 <= gated(cfg_regs.control_word_0, fifo_data,
                                           cfg_regs.control_write_gate);
        end
        cfg_pkt_pkg::ADDR_CONTROL_WORD_1: begin
          cfg_regs.control_word_1 <= gated(cfg_regs.control_word_1, fifo_data,
                                           cfg_regs.control_write_gate);
        end
        // reserved and unknown addresses swallow the payload
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // identity check; sticky until reset, or until a reprogram with no mismatching identity write in the same cycle

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      config_error <= 1'b0;
    end else if (pay_take && addr_reg == cfg_pkt_pkg::ADDR_IDENT &&
                 fifo_data != DEVICE_ID) begin
      config_error <= 1'b1;
    end else if (reprogram_req) begin
      config_error <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // running crc; coverage starts with the word after the clear command

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crc_value       <= cfg_pkt_pkg::CRC_RESET;
      crc_covering    <= 1'b0;
      crc_clear_pulse <= 1'b0;
    end else if (reprogram_req) begin
      crc_value       <= cfg_pkt_pkg::CRC_RESET;
      crc_covering    <= 1'b0;
      crc_clear_pulse <= 1'b0;
    end else begin
      crc_clear_pulse <= 1'b0;
      if (pay_take && addr_reg == cfg_pkt_pkg::ADDR_COMMAND &&
          cmd_code == cfg_pkt_pkg::CMD_CRC_CLEAR) begin
        crc_value       <= cfg_pkt_pkg::CRC_RESET;
        crc_covering    <= 1'b1;
        crc_clear_pulse <= 1'b1;
      end else if (take && crc_covering && state_reg != ST_HUNT) begin
        crc_value <= crc_step(crc_value, fifo_data);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock switch; the stream is held while the new clock settles

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      config_clock_select <= '0;
      clock_switch_pulse  <= 1'b0;
      settle_reg          <= '0;
    end else begin
      clock_switch_pulse <= 1'b0;
      if (pay_take && addr_reg == cfg_pkt_pkg::ADDR_COMMAND &&
          cmd_code == cfg_pkt_pkg::CMD_CLOCK_SWITCH) begin
        config_clock_select <= cfg_regs.config_option_0[
          cfg_pkt_pkg::FREQ_LSB +: cfg_pkt_pkg::FREQ_WIDTH];
        clock_switch_pulse  <= 1'b1;
        settle_reg          <= SETTLE_W'(cfg_pkt_pkg::SWITCH_SETTLE_CYCLES);
      end else if (settle_reg != '0) begin
        settle_reg <= settle_reg - 1'b1;
      end
    end
  end

endmodule

// file: config_packet_processor_assertions.sv
// port-level assertions for the configuration packet processor
module config_packet_processor_assertions #(
  parameter logic [31:0] DEVICE_ID  = cfg_pkt_pkg::DEVICE_ID_DEFAULT,
  parameter int          FIFO_DEPTH = 8
) (
  // clock and control
  input wire logic                            clk_sys,
  input wire logic                            rst_n,
  input wire logic                            reprogram_req,
  // word stream
  input wire logic                            word_valid,
  input wire logic [31:0]                     word_data,
  input wire logic                            word_ready,
  // registers and status
  input wire cfg_pkt_pkg::cfg_regs_type       cfg_regs,
  input wire logic                            word_aligned_flag,
  input wire logic                            config_error,
  input wire logic                            crc_covering,
  input wire logic [31:0]                     crc_value,
  input wire logic                            crc_clear_pulse,
  input wire logic                            clock_switch_pulse,
  input wire logic [cfg_pkt_pkg::FREQ_WIDTH-1:0] config_clock_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_clear_single: assert property (crc_clear_pulse |=> !crc_clear_pulse)
    else $error("crc clear pulse too long");
  chk_cover_follows: assert property (crc_clear_pulse && !reprogram_req |-> ##[0:1] crc_covering)
    else $error("coverage not set after crc clear");
  chk_switch_sel: assert property (clock_switch_pulse |-> ##[0:1] (config_clock_select ==
    cfg_regs.config_option_0[cfg_pkt_pkg::FREQ_LSB +: cfg_pkt_pkg::FREQ_WIDTH]))
    else $error("clock select differs from option word");
  chk_error_sticky: assert property (config_error && !reprogram_req |=> config_error)
    else $error("configuration error dropped");
  chk_error_cause: assert property ($rose(config_error) |-> ##[0:1]
    (cfg_regs.device_identity_check != DEVICE_ID))
    else $error("error raised on matching identity");
  // a gate write and a control write never land on the same edge
  chk_gate_mask: assert property (!$past(reprogram_req) |->
    ((((cfg_regs.control_word_0 ^ $past(cfg_regs.control_word_0)) |
    (cfg_regs.control_word_1 ^ $past(cfg_regs.control_word_1))) &
    ~$past(cfg_regs.control_write_gate)) == 32'h0000_0000))
    else $error("control bit changed outside gate");
  chk_release_drop: assert property ($fell(word_aligned_flag) && !$past(reprogram_req)
    |-> ##[0:1] (cfg_regs.command_reg[4:0] == cfg_pkt_pkg::CMD_ALIGN_RELEASE))
    else $error("alignment lost without release command");
  // two cycles of margin for register updates still in flight
  chk_unaligned_frozen: assert property (!word_aligned_flag && !$past(word_aligned_flag, 2)
    && !$past(reprogram_req) && !$past(reprogram_req, 2) |-> $stable(cfg_regs))
    else $error("register changed while unaligned");

  cov_clear: cover property (crc_clear_pulse);
  cov_switch: cover property (clock_switch_pulse);
  cov_refuse: cover property (word_valid && !word_ready);
endmodule

bind config_packet_processor config_packet_processor_assertions #(
  .DEVICE_ID(DEVICE_ID), .FIFO_DEPTH(FIFO_DEPTH)
) i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reprogram_req(reprogram_req),
  .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
  .cfg_regs(cfg_regs), .word_aligned_flag(word_aligned_flag),
  .config_error(config_error), .crc_covering(crc_covering), .crc_value(crc_value),
  .crc_clear_pulse(crc_clear_pulse), .clock_switch_pulse(clock_switch_pulse),
  .config_clock_select(config_clock_select));

// file: config_packet_processor_tb_top.sv
// self-checking bench for the configuration packet processor
module config_packet_processor_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // arbitrary identity code for the simulated part
  localparam logic [31:0] OWN_ID = 32'h0BAD_CAFE;
  localparam logic [31:0] OPT0   = 32'h0046_3FE5;
  logic                      clk_sys = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      reprogram_req = 1'b0;
  logic                      word_valid;
  logic [31:0]               word_data;
  logic                      word_ready;
  cfg_pkt_pkg::cfg_regs_type cfg_regs;
  logic                      aligned;
  logic                      config_error;
  logic                      crc_covering;
  logic [31:0]               crc_value;
  logic                      crc_clear_pulse;
  logic                      clock_switch_pulse;
  logic [5:0]                clk_sel;
  int                        err_total = 0;
  int                        n_checks = 0;
  int                        n_clear = 0;
  int                        n_switch = 0;

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (crc_clear_pulse === 1'b1) n_clear++;
    if (clock_switch_pulse === 1'b1) n_switch++;
  end

  cfg_word_source i_src (.clk_sys(clk_sys), .rst_n(rst_n), .word_valid(word_valid),
    .word_data(word_data), .word_ready(word_ready));
  config_packet_processor #(.DEVICE_ID(OWN_ID), .FIFO_DEPTH(8)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reprogram_req(reprogram_req),
    .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
    .cfg_regs(cfg_regs), .word_aligned_flag(aligned), .config_error(config_error),
    .crc_covering(crc_covering), .crc_value(crc_value),
    .crc_clear_pulse(crc_clear_pulse), .clock_switch_pulse(clock_switch_pulse),
    .config_clock_select(clk_sel));

  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (i_src.hung) err_total++;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
    if (i_src.hung) tally_and_finish();
  endtask
  task automatic wr(input logic [31:0] hdr, input logic [31:0] val);
    i_src.send(hdr);
    i_src.send(val);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 10; i++) check("reg", cfg_regs[32*i +: 32], 32'h0000_0000);
    check("crc", crc_value, 32'hFFFF_FFFF);
    check("aligned", aligned, 1'b0);
    check("error", config_error, 1'b0);
  endtask
  task automatic t_hunt();
    i_src.preamble();
    wr(32'h3000_8001, 32'h0000_0007);
    i_src.idle(6);
    check("cmd", cfg_regs.command_reg, 32'h0000_0000);
    check("aligned", aligned, 1'b0);
    i_src.send(cfg_pkt_pkg::SYNC_WORD);
    i_src.send(cfg_pkt_pkg::IDLE_WORD);
    i_src.idle(6);
    check("aligned", aligned, 1'b1);
  endtask
  task automatic t_regs();
    wr(32'h3002_2001, 32'h1234_5678);
    wr(32'h3002_0001, 32'h9ABC_DEF0);
    wr(32'h3000_2001, 32'h03BE_0000);
    wr(32'h3002_6001, 32'h3000_8001);
    i_src.send(cfg_pkt_pkg::IDLE_WORD);
    wr(32'h3001_2001, OPT0);
    wr(32'h3001_C001, 32'h0000_0003);
    wr(32'h3001_8001, OWN_ID);
    wr(32'h2802_2001, 32'hDEAD_0000);
    i_src.idle(6);
    check("wdog", cfg_regs.fallback_watchdog_value, 32'h1234_5678);
    check("wboot", cfg_regs.warm_boot_start_address, 32'h9ABC_DEF0);
    check("frame", cfg_regs.frame_address, 32'h03BE_0000);
    check("cmd", cfg_regs.command_reg, 32'h0000_0000);
    check("opt0", cfg_regs.config_option_0, OPT0);
    check("opt1", cfg_regs.config_option_1, 32'h0000_0003);
    check("ident", cfg_regs.device_identity_check, OWN_ID);
    check("error", config_error, 1'b0);
  endtask
  task automatic t_gate();
    wr(32'h3000_C001, 32'h0000_0000);
    wr(32'h3000_A001, 32'h0000_0501);
    i_src.idle(6);
    check("control_word_0", cfg_regs.control_word_0, 32'h0000_0000);
    wr(32'h3000_C001, 32'h0000_0100);
    wr(32'h3000_A001, 32'h0000_0501);
    wr(32'h3000_C001, 32'hFFFF_0000);
    wr(32'h3003_0001, 32'h1234_5678);
    i_src.idle(6);
    check("gate", cfg_regs.control_write_gate, 32'hFFFF_0000);
    check("control_word_0", cfg_regs.control_word_0, 32'h0000_0100);
    check("control_word_1", cfg_regs.control_word_1, 32'h1234_0000);
    wr(32'h3003_0001, 32'h0000_0000);
    i_src.idle(6);
    check("control_word_1", cfg_regs.control_word_1, 32'h0000_0000);
  endtask
  task automatic t_cmds();
    int c0;
    int s0;
    int r0;
    c0 = n_clear;
    s0 = n_switch;
    wr(32'h3000_8001, 32'h0000_0000);
    i_src.idle(6);
    check("nclear", n_clear - c0, 0);
    check("cover", crc_covering, 1'b0);
    wr(32'h3000_8001, 32'h0000_0007);
    i_src.idle(6);
    check("nclear", n_clear - c0, 1);
    check("cover", crc_covering, 1'b1);
    r0 = i_src.refused;
    // the decoder stall after a switch must back the fifo up to refusal
    wr(32'h3000_8001, 32'h0000_0009);
    repeat (12) i_src.send(cfg_pkt_pkg::IDLE_WORD);
    check("refused", i_src.refused > r0, 1'b1);
    i_src.idle(6);
    check("ready", word_ready, 1'b1);
    check("nswitch", n_switch - s0, 1);
    check("clksel", clk_sel, OPT0[22:17]);
    check("cmd", cfg_regs.command_reg, 32'h0000_0009);
  endtask
  task automatic t_ident();
    wr(32'h3001_8001, ~OWN_ID);
    i_src.idle(6);
    check("error", config_error, 1'b1);
    wr(32'h3001_8001, OWN_ID);
    i_src.idle(6);
    check("error", config_error, 1'b1);
  endtask
  task automatic t_release();
    wr(32'h3000_8001, 32'h0000_000D);
    wr(32'h3002_2001, 32'hFFFF_FFFF);
    i_src.idle(6);
    check("aligned", aligned, 1'b0);
    check("wdog", cfg_regs.fallback_watchdog_value, 32'h1234_5678);
    i_src.send(cfg_pkt_pkg::SYNC_WORD);
    wr(32'h3002_2001, 32'h0000_0000);
    wr(32'h3000_2001, 32'h0000_0000);
    i_src.idle(6);
    check("aligned", aligned, 1'b1);
    check("frame", cfg_regs.frame_address, 32'h0000_0000);
    check("wdog", cfg_regs.fallback_watchdog_value, 32'h0000_0000);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_hunt();
    t_regs();
    t_gate();
    t_cmds();
    t_ident();
    t_release();
    reprogram_req = 1'b1;
    i_src.idle(2);
    reprogram_req = 1'b0;
    i_src.idle(6);
    t_reset();
    tally_and_finish();
  end
endmodule
